//--- hw/tst_pkg.sv
// package for the trip solenoid test sequencer: register map, timing, encodings
package tst_pkg;

  // ---------------------------------------------------------------
  // register map (byte offsets on the apb bus)
  // ---------------------------------------------------------------
  localparam logic [11:0] REG_CTRL     = 12'h000;
  localparam logic [11:0] REG_RECHARGE = 12'h004;
  localparam logic [11:0] REG_SETTLE   = 12'h008;
  localparam logic [11:0] REG_PST_POS  = 12'h00C;
  localparam logic [11:0] REG_STATUS   = 12'h010;
  localparam logic [11:0] REG_FAIL     = 12'h014;

  // ---------------------------------------------------------------
  // field positions and reset values
  // ---------------------------------------------------------------
  localparam int CTRL_LOCAL_BIT = 0;   // 1 = local mode, 0 = remote mode
  localparam logic [15:0] RECHARGE_RST = 16'h0BB8;  // recharge pressure, psi
  localparam logic [31:0] SETTLE_RST   = 32'h0000_C350; // settle cycles
  localparam logic [9:0]  PST_POS_RST  = 10'h384;   // pst target, 0.1 %

  // ---------------------------------------------------------------
  // pressure and position constants
  // ---------------------------------------------------------------
  localparam logic [15:0] UPPER_OFFSET_PSI = 16'h01F4;  // 500 psi below recharge
  localparam logic [15:0] LOWER_PSI        = 16'h0096;  // 150 psi, fixed
  localparam logic [9:0]  POS_FULL_OPEN    = 10'h3E8;   // 100.0 %
  localparam logic [9:0]  DRIFT_LIMIT      = 10'h032;   // 5.0 %

  // ---------------------------------------------------------------
  // timing
  // ---------------------------------------------------------------
  localparam longint CLK_HZ       = 50_000_000;
  localparam longint PASS_SECONDS = 120;    // 2 minutes
  localparam longint PASS_CYCLES  = PASS_SECONDS * CLK_HZ;

  // ---------------------------------------------------------------
  // solenoid patterns, bit 0 = trip_sol_1 .. bit 3 = trip_sol_4
  // ---------------------------------------------------------------
  localparam logic [3:0] SOL_NORMAL = 4'b1111;
  localparam logic [3:0] SOL_STAGE1 = 4'b0100;
  localparam logic [3:0] SOL_STAGE2 = 4'b0001;
  localparam logic [3:0] SOL_STAGE3 = 4'b0100;
  localparam logic [3:0] SOL_STAGE4 = 4'b1000;
  localparam logic [3:0] SOL_STAGE5 = 4'b0010;
  localparam logic [3:0] SOL_STAGE6 = 4'b0001;

  // ---------------------------------------------------------------
  // display selections
  // ---------------------------------------------------------------
  localparam logic [1:0] MSG_NORMAL = 2'h0;
  localparam logic [1:0] MSG_PASS   = 2'h1;
  localparam logic [1:0] MSG_DRIFT  = 2'h2;
  localparam logic [1:0] MSG_FAIL   = 2'h3;

  // sequencer states, one-hot
  typedef enum logic [8:0] {
    TST_IDLE   = 9'b0_0000_0001,
    TST_STAGE1 = 9'b0_0000_0010,
    TST_STAGE2 = 9'b0_0000_0100,
    TST_STAGE3 = 9'b0_0000_1000,
    TST_STAGE4 = 9'b0_0001_0000,
    TST_STAGE5 = 9'b0_0010_0000,
    TST_STAGE6 = 9'b0_0100_0000,
    TST_PASS   = 9'b0_1000_0000,
    TST_STOP   = 9'b1_0000_0000
  } tst_state_e;

  // partial stroke test states, one-hot
  typedef enum logic [2:0] {
    TST_PST_IDLE   = 3'b001,
    TST_PST_OUT    = 3'b010,
    TST_PST_RETURN = 3'b100
  } tst_pst_e;

endpackage : tst_pkg

//--- hw/tst_sequencer.sv
// trip solenoid test sequencer with apb register slave
//
// Function
// - normally solenoids one to four energized, fifth solenoid off
// - trip only when both safety trip inputs lost power
// - inhibit lamp and trip disabled when any isolation valve not open
// - green lamp per valve 2 and 4 while that valve fully open
// - trip disabled opens warning and alarm relays, shows inhibit alarm
// - partial stroke drives to set position then back to start
// - partial stroke only at full open; aborted on control change
// - test button enters remote or local test mode, starts sequence
// - test display shows manifold pressures and retract, extend in stage 5
// - hold position; drift over 5 percent closed stops, shows drift text
// - partial stroke requests ignored while solenoid test runs
// - upper threshold is recharge minus 500 psi; lower fixed 150 psi
// - stage 1 drops sols 1,2,4; all three above upper else fail 1
// - stage 2 sol 1 on, 3 off; all three below lower else fail 2
// - stage 3 sol 3 on, 1 off; all three above upper else fail 3
// - stage 4 sol 4 on, 3 off; retract above lower else fail 4
// - stage 5 sol 2 on, 4 off; extend below lower else fail 5
// - stage 6 sol 1 on, 2 off; manifold a below lower else fail 6
// - any stage failure stops, restores solenoids, shows stage warning
// - failure warning latched until a later full sequence passes
// - full pass restores solenoids, prior mode, shows pass text
// - pass text shown two minutes after mode restored
module tst_sequencer #(
  parameter longint PASS_CYCLES_P = tst_pkg::PASS_CYCLES
) (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        trip_in_1,
  input  wire logic        trip_in_2,
  input  wire logic [3:0]  iso_open,
  input  wire logic        solenoid_test_button,
  input  wire logic        partial_stroke_test_button,
  input  wire logic [15:0] manifold_pressure_a,
  input  wire logic [15:0] manifold_pressure_b,
  input  wire logic [15:0] retract_pressure,
  input  wire logic [15:0] extend_pressure,
  input  wire logic [9:0]  position,
  input  wire logic [9:0]  control_setpoint,
  output logic [3:0]       trip_sol,
  output logic             sol_5,
  output logic             trip_active,
  output logic             trip_inhibit_lamp,
  output logic             iso_2_lamp,
  output logic             iso_4_lamp,
  output logic             warning_relay_closed,
  output logic             alarm_relay_closed,
  output logic             trip_inhibit_alarm,
  output logic             remote_test_mode,
  output logic             local_test_mode,
  output logic             hold_position,
  output logic             pst_drive,
  output logic [9:0]       pst_target,
  output logic [15:0]      disp_position,
  output logic [15:0]      disp_date,
  output logic [15:0]      disp_time,
  output logic [1:0]       disp_message,
  output logic [5:0]       step_fail
);
  import tst_pkg::*;

  // ---------------------------------------------------------------
  // input synchronisers
  // ---------------------------------------------------------------
  logic [7:0] sync_a;
  logic [7:0] sync_b;
  logic       trip_1_s, trip_2_s, sol_btn_s, pst_btn_s;
  logic [3:0] iso_s;
  logic       sol_btn_d, pst_btn_d;

  // two flops on the trip, isolation and button inputs; pressures and positions unsynchronised
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sync_a <= 8'h00;
      sync_b <= 8'h00;
    end else begin
      sync_a <= {trip_in_1, trip_in_2, iso_open, solenoid_test_button,
                 partial_stroke_test_button};
      sync_b <= sync_a;
    end
  end
  assign {trip_1_s, trip_2_s, iso_s, sol_btn_s, pst_btn_s} = sync_b;

  // edge detectors read the second flop only
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sol_btn_d <= 1'b0;
      pst_btn_d <= 1'b0;
    end else begin
      sol_btn_d <= sol_btn_s;
      pst_btn_d <= pst_btn_s;
    end
  end
  wire sol_press = sol_btn_s & ~sol_btn_d;
  wire pst_press = pst_btn_s & ~pst_btn_d;

  // ---------------------------------------------------------------
  // apb registers
  // ---------------------------------------------------------------
  logic        mode_local;
  logic [15:0] recharge_psi;
  logic [31:0] settle_cycles;
  logic [9:0]  pst_pos;
  wire         apb_wr = psel & penable & pwrite;
  wire         apb_rd = psel & ~pwrite;
  wire         addr_ok = (paddr == REG_CTRL) || (paddr == REG_RECHARGE) ||
                         (paddr == REG_SETTLE) || (paddr == REG_PST_POS) ||
                         (paddr == REG_STATUS) || (paddr == REG_FAIL);
  tst_state_e  state;

  // writable configuration; lower threshold has no register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mode_local    <= 1'b0;
      recharge_psi  <= RECHARGE_RST;
      settle_cycles <= SETTLE_RST;
      pst_pos       <= PST_POS_RST;
    end else if (apb_wr) begin
      unique case (paddr)
        REG_CTRL:     mode_local    <= pwdata[CTRL_LOCAL_BIT];
        REG_RECHARGE: recharge_psi  <= pwdata[15:0];
        REG_SETTLE:   settle_cycles <= pwdata;
        REG_PST_POS:  pst_pos       <= pwdata[9:0];
        default:      ;
      endcase
    end
  end

  // no wait states: answer in the first access cycle, error on unmapped
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata  <= 32'h0000_0000;
      pready  <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      pready  <= psel & ~penable;
      pslverr <= psel & ~penable & ~addr_ok;
      if (apb_rd & ~penable) begin
        unique case (paddr)
          REG_CTRL:     prdata <= {31'h0000_0000, mode_local};
          REG_RECHARGE: prdata <= {16'h0000, recharge_psi};
          REG_SETTLE:   prdata <= settle_cycles;
          REG_PST_POS:  prdata <= {22'h00_0000, pst_pos};
          REG_STATUS:   prdata <= {21'h00_0000, trip_inhibit_lamp, trip_active,
                                   state};
          REG_FAIL:     prdata <= {26'h000_0000, step_fail};
          default:      prdata <= 32'h0000_0000;
        endcase
      end
    end
  end

  // ---------------------------------------------------------------
  // thresholds and comparisons
  // ---------------------------------------------------------------
  wire [15:0] upper_test_threshold = recharge_psi - UPPER_OFFSET_PSI;
  wire [15:0] lower_test_threshold = LOWER_PSI;
  wire all_above = (manifold_pressure_a > upper_test_threshold) &&
                   (retract_pressure > upper_test_threshold) &&
                   (manifold_pressure_b > upper_test_threshold);
  wire all_below = (manifold_pressure_a < lower_test_threshold) &&
                   (retract_pressure < lower_test_threshold) &&
                   (manifold_pressure_b < lower_test_threshold);
  wire trip_disabled = ~&iso_s;
  wire testing = (state != TST_IDLE) && (state != TST_PASS) && (state != TST_STOP);

  // ---------------------------------------------------------------
  // solenoid test sequencer
  // ---------------------------------------------------------------
  logic [31:0] settle_cnt;
  logic [63:0] pass_cnt;
  logic [9:0]  hold_pos;
  logic        drift;
  logic        stage_ok;
  logic [3:0]  stage_sol;
  tst_state_e  next_state;
  wire         settled = (settle_cnt >= settle_cycles);
  wire [10:0]  drift_ref = {1'b0, position} + {1'b0, DRIFT_LIMIT};
  assign drift = testing && (drift_ref < {1'b0, hold_pos});

  // stage pattern, pass test and successor
  always_comb begin
    stage_sol  = SOL_NORMAL;
    stage_ok   = 1'b0;
    next_state = state;
    unique case (state)
      TST_STAGE1: begin stage_sol = SOL_STAGE1; stage_ok = all_above;
                  next_state = TST_STAGE2; end
      TST_STAGE2: begin stage_sol = SOL_STAGE2; stage_ok = all_below;
                  next_state = TST_STAGE3; end
      TST_STAGE3: begin stage_sol = SOL_STAGE3; stage_ok = all_above;
                  next_state = TST_STAGE4; end
      TST_STAGE4: begin stage_sol = SOL_STAGE4;
                  stage_ok = retract_pressure > lower_test_threshold;
                  next_state = TST_STAGE5; end
      TST_STAGE5: begin stage_sol = SOL_STAGE5;
                  stage_ok = extend_pressure < lower_test_threshold;
                  next_state = TST_STAGE6; end
      TST_STAGE6: begin stage_sol = SOL_STAGE6;
                  stage_ok = manifold_pressure_a < lower_test_threshold;
                  next_state = TST_PASS; end
      TST_IDLE, TST_PASS, TST_STOP: ;
    endcase
  end

  // state, settle timer and failure latch
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state      <= TST_IDLE;
      settle_cnt <= 32'h0000_0000;
      pass_cnt   <= 64'h0;
      hold_pos   <= 10'h000;
      step_fail  <= 6'h00;
    end else begin
      unique case (state)
        TST_IDLE, TST_STOP: if (sol_press) begin
          state      <= TST_STAGE1;
          settle_cnt <= 32'h0000_0000;
          hold_pos   <= position;
        end
        TST_PASS: begin
          pass_cnt <= pass_cnt + 64'h1;
          if (pass_cnt >= 64'(PASS_CYCLES_P - 1)) state <= TST_IDLE;
          if (sol_press) begin
            state      <= TST_STAGE1;
            settle_cnt <= 32'h0000_0000;
            hold_pos   <= position;
          end
        end
        default: begin
          if (drift) begin
            state <= TST_STOP;
          end else if (!settled) begin
            settle_cnt <= settle_cnt + 32'h0000_0001;
          end else if (stage_ok) begin
            state      <= next_state;
            settle_cnt <= 32'h0000_0000;
            pass_cnt   <= 64'h0;
            if (next_state == TST_PASS) step_fail <= 6'h00;
          end else begin
            state <= TST_STOP;
            step_fail <= step_fail | {state[6:1]};
          end
        end
      endcase
    end
  end

  // solenoid drivers; sol 5 is never energised by this block
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      trip_sol <= SOL_NORMAL;
      sol_5    <= 1'b0;
    end else begin
      trip_sol <= (testing && !drift) ? stage_sol : SOL_NORMAL;
      sol_5    <= 1'b0;
    end
  end

  // ---------------------------------------------------------------
  // trip, lamps, relays and mode outputs
  // ---------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      trip_active          <= 1'b0;
      trip_inhibit_lamp    <= 1'b0;
      iso_2_lamp           <= 1'b0;
      iso_4_lamp           <= 1'b0;
      warning_relay_closed <= 1'b0;
      alarm_relay_closed   <= 1'b0;
      trip_inhibit_alarm   <= 1'b0;
      remote_test_mode     <= 1'b0;
      local_test_mode      <= 1'b0;
      hold_position        <= 1'b0;
    end else begin
      trip_active          <= ~trip_1_s & ~trip_2_s & ~trip_disabled;
      trip_inhibit_lamp    <= trip_disabled;
      iso_2_lamp           <= iso_s[1];
      iso_4_lamp           <= iso_s[3];
      warning_relay_closed <= ~trip_disabled;
      alarm_relay_closed   <= ~trip_disabled;
      trip_inhibit_alarm   <= trip_disabled;
      remote_test_mode     <= testing & ~mode_local;
      local_test_mode      <= testing & mode_local;
      hold_position        <= testing;
    end
  end

  // display: pressures replace normal fields during the test
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      disp_position <= 16'h0000;
      disp_date     <= 16'h0000;
      disp_time     <= 16'h0000;
      disp_message  <= MSG_NORMAL;
    end else begin
      disp_position <= testing ? manifold_pressure_a : {6'h00, position};
      disp_date     <= testing ? manifold_pressure_b : 16'h0000;
      disp_time     <= !testing ? 16'h0000 :
                       (state == TST_STAGE5) ? extend_pressure : retract_pressure;
      if (testing && drift)
        disp_message <= MSG_DRIFT;
      else if (state == TST_PASS)
        disp_message <= MSG_PASS;
      else if (state == TST_IDLE || testing)
        disp_message <= (|step_fail) ? MSG_FAIL : MSG_NORMAL;
      else
        // a stop on drift keeps the drift text; a stage failure shows its warning
        disp_message <= (disp_message == MSG_DRIFT) ? MSG_DRIFT :
                        (|step_fail) ? MSG_FAIL : disp_message;
    end
  end

  // ---------------------------------------------------------------
  // partial stroke test
  // ---------------------------------------------------------------
  tst_pst_e   pst_state;
  logic [9:0] pst_origin;
  logic [9:0] pst_ctrl;

  // out to the set position, back to the origin, abort on control change
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pst_state  <= TST_PST_IDLE;
      pst_origin <= 10'h000;
      pst_ctrl   <= 10'h000;
      pst_drive  <= 1'b0;
      pst_target <= 10'h000;
    end else begin
      unique case (pst_state)
        TST_PST_IDLE: if (pst_press && !testing && position == POS_FULL_OPEN) begin
          pst_state  <= TST_PST_OUT;
          pst_origin <= position;
          pst_ctrl   <= control_setpoint;
          pst_drive  <= 1'b1;
          pst_target <= pst_pos;
        end
        TST_PST_OUT: begin
          if (control_setpoint != pst_ctrl) begin
            pst_state <= TST_PST_IDLE;
            pst_drive <= 1'b0;
          end else if (position == pst_target) begin
            pst_state  <= TST_PST_RETURN;
            pst_target <= pst_origin;
          end
        end
        TST_PST_RETURN: if (control_setpoint != pst_ctrl || position == pst_origin) begin
          pst_state <= TST_PST_IDLE;
          pst_drive <= 1'b0;
        end
      endcase
    end
  end

  // ---------------------------------------------------------------
  // assertions
  // ---------------------------------------------------------------
  property p_idle_normal;
    @(posedge pclk) disable iff (!presetn)
      $past(state == TST_IDLE) |-> (trip_sol == SOL_NORMAL && !sol_5);
  endproperty
  a_idle_normal: assert property (p_idle_normal) else $error("solenoids not normal");

  property p_inhibit;
    @(posedge pclk) disable iff (!presetn)
      trip_disabled |=> trip_inhibit_lamp && !alarm_relay_closed && trip_inhibit_alarm;
  endproperty
  a_inhibit: assert property (p_inhibit) else $error("inhibit indication missing");

  property p_trip_both;
    @(posedge pclk) disable iff (!presetn)
      (trip_1_s || trip_2_s) |=> !trip_active;
  endproperty
  a_trip_both: assert property (p_trip_both) else $error("trip with one input");

  property p_stage1_sol;
    @(posedge pclk) disable iff (!presetn)
      (state == TST_STAGE1 && !drift) |=> trip_sol == SOL_STAGE1;
  endproperty
  a_stage1_sol: assert property (p_stage1_sol) else $error("stage 1 pattern wrong");

  property p_fail_stop;
    @(posedge pclk) disable iff (!presetn)
      (testing && !drift && settled && !stage_ok) |=> state == TST_STOP ##1
        trip_sol == SOL_NORMAL;
  endproperty
  a_fail_stop: assert property (p_fail_stop) else $error("failure not handled");

  property p_pst_ignored;
    @(posedge pclk) disable iff (!presetn)
      (testing && pst_state == TST_PST_IDLE) |=> !pst_drive;
  endproperty
  a_pst_ignored: assert property (p_pst_ignored) else $error("pst during test");

  property p_fail_latched;
    @(posedge pclk) disable iff (!presetn)
      (step_fail != 6'h00 && !(settled && stage_ok && state == TST_STAGE6))
        |=> (step_fail & $past(step_fail)) == $past(step_fail);
  endproperty
  a_fail_latched: assert property (p_fail_latched) else $error("fail code lost");

  property p_drift_stop;
    @(posedge pclk) disable iff (!presetn)
      drift |=> state == TST_STOP && disp_message == MSG_DRIFT;
  endproperty
  a_drift_stop: assert property (p_drift_stop) else $error("drift not stopped");

endmodule // tst_sequencer

//--- verification/tst_hydraulics.sv
// partner model: trip block transducers answering the solenoid pattern
module tst_hydraulics (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic [3:0]  trip_sol,
  input  wire logic [2:0]  wrong,
  output logic      [15:0] manifold_pressure_a,
  output logic      [15:0] manifold_pressure_b,
  output logic      [15:0] retract_pressure,
  output logic      [15:0] extend_pressure
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [2:0] stg;
  logic [3:0] last;
  logic       flip;
  // stage index: pattern changes counted since leaving the normal pattern
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      stg  <= 3'h0;
      last <= 4'hF;
    end else begin
      last <= trip_sol;
      if (trip_sol == 4'hF) stg <= 3'h0;
      else if (trip_sol != last) stg <= stg + 3'h1;
    end
  end
  // healthy valves hold pressure in stages 1 and 3 (retract also 4)
  assign flip = (stg != 3'h0) && (stg == wrong);  // faulty valve inverts
  assign manifold_pressure_a = ((stg == 3'h1 || stg == 3'h3) ^ flip) ? 16'h0A28 : 16'h0064;
  assign manifold_pressure_b = manifold_pressure_a;
  assign retract_pressure = ((stg == 3'h1 || stg == 3'h3 || stg == 3'h4) ^ flip)
                            ? 16'h0A28 : 16'h0064;
  assign extend_pressure = flip ? 16'h0A28 : 16'h0064;
endmodule // tst_hydraulics

//--- verification/trip_solenoid_test_sequencer_test.sv
// self-checking bench for the trip solenoid test sequencer
module trip_solenoid_test_sequencer_test;
  import tst_pkg::*;
  timeunit 1ns;
  timeprecision 1ns;
  logic        pclk = 1'b0, presetn = 1'b0, psel, penable, pwrite, b_test, b_pst;
  logic        trip_in_1, trip_in_2, pready, pslverr, err, sol_5, trip_active;
  logic        lamp, iso2, iso4, warn, alarm, talarm, rmode, lmode, pst_drive;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, q, exp;
  logic [3:0]  iso_open, trip_sol;
  logic [15:0] pma, pmb, pr, pe;
  logic [9:0]  position;
  logic [2:0]  wrong;
  logic [1:0]  disp_message;
  logic [5:0]  step_fail;
  int          err_total = 0, checked = 0, n;
  always #10 pclk = ~pclk;
  tst_sequencer #(.PASS_CYCLES_P(20)) u_dut (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .trip_in_1(trip_in_1), .trip_in_2(trip_in_2),
    .iso_open(iso_open), .solenoid_test_button(b_test), .partial_stroke_test_button(b_pst),
    .manifold_pressure_a(pma), .manifold_pressure_b(pmb), .retract_pressure(pr),
    .extend_pressure(pe), .position(position), .control_setpoint(10'h3E8),
    .trip_sol(trip_sol), .sol_5(sol_5), .trip_active(trip_active), .trip_inhibit_lamp(lamp),
    .iso_2_lamp(iso2), .iso_4_lamp(iso4), .warning_relay_closed(warn),
    .alarm_relay_closed(alarm), .trip_inhibit_alarm(talarm), .remote_test_mode(rmode),
    .local_test_mode(lmode), .hold_position(), .pst_drive(pst_drive), .pst_target(),
    .disp_position(), .disp_date(), .disp_time(), .disp_message(disp_message),
    .step_fail(step_fail));
  tst_hydraulics u_hyd (.pclk(pclk), .presetn(presetn), .trip_sol(trip_sol), .wrong(wrong),
    .manifold_pressure_a(pma), .manifold_pressure_b(pmb), .retract_pressure(pr),
    .extend_pressure(pe));
  // compare and count
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    checked++;
    if (g !== e) begin
      err_total++;
      $display("BAD %s expected %h seen %h", nm, e, g);
    end
  endtask
  // one apb transfer: setup, then access until pready
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin @(posedge pclk); n++; end while (pready !== 1'b1 && n < 20);
    q = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wait_msg(input logic [1:0] m);
    n = 0;
    while (disp_message !== m && n < 400) begin @(posedge pclk); n++; end
    chk("disp_message", m, disp_message);
  endtask
  task automatic press;
    @(posedge pclk);
    b_test <= 1'b1;
    repeat (5) @(posedge pclk);
    b_test <= 1'b0;
  endtask
  task automatic wrap_up;
    if (err_total == 0 && checked > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  // hang guard
  initial begin
    #400_000;
    err_total++;
    wrap_up();
  end
  // main sequence
  initial begin
    {psel, penable, pwrite, b_test, b_pst, trip_in_1, trip_in_2} = '0;
    {paddr, pwdata, wrong} = '0;
    iso_open = 4'hF;
    position = 10'h3E8;
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    repeat (5) @(posedge pclk);
    chk("sols", {1'b0, SOL_NORMAL}, {sol_5, trip_sol});
    chk("trip_active", 1, trip_active);
    trip_in_2 <= 1'b1;
    iso_open <= 4'hA;
    repeat (5) @(posedge pclk);
    chk("trip_active", 0, trip_active);
    chk("lamps", 6'h3C, {iso2, iso4, lamp, talarm, warn, alarm});
    trip_in_2 <= 1'b0;
    iso_open <= 4'hF;
    apb(1'b0, REG_RECHARGE, 0);
    chk("recharge", {16'h0, RECHARGE_RST}, q);
    apb(1'b0, 12'h0FC, 0);
    chk("slverr", 1, err);
    apb(1'b1, REG_SETTLE, 3);
    exp = 0;
    for (int k = 1; k <= 6; k++) begin
      wrong <= k[2:0];
      press();
      exp[k-1] = 1'b1;
      n = 0;
      while (step_fail !== exp[5:0] && n < 400) begin @(posedge pclk); n++; end
      chk("step_fail", exp, step_fail);
      wait_msg(MSG_FAIL);
      repeat (2) @(posedge pclk);
      chk("trip_sol", SOL_NORMAL, trip_sol);
    end
    wrong <= 3'h0;
    press();
    chk("modes", 2'b10, {rmode, lmode});
    b_pst <= 1'b1;
    position <= 10'h384;
    wait_msg(MSG_DRIFT);
    chk("pst_drive", 0, pst_drive);
    b_pst <= 1'b0;
    position <= 10'h3E8;
    apb(1'b1, REG_CTRL, 1);
    press();
    chk("modes", 2'b01, {rmode, lmode});
    wait_msg(MSG_PASS);
    repeat (2) @(posedge pclk);
    chk("after pass", {SOL_NORMAL, 8'h0}, {trip_sol, rmode, lmode, step_fail});
    wait_msg(MSG_NORMAL);
    chk("pass span", 1, n > 10);
    b_pst <= 1'b1;
    repeat (5) @(posedge pclk);
    chk("pst_drive", 1, pst_drive);
    b_pst <= 1'b0;
    position <= PST_POS_RST;
    repeat (3) @(posedge pclk);
    chk("pst_drive", 1, pst_drive);
    position <= POS_FULL_OPEN;
    repeat (3) @(posedge pclk);
    chk("pst_drive", 0, pst_drive);
    wrap_up();
  end
endmodule // trip_solenoid_test_sequencer_test
